/* hw/crdic_regs.svh */
`ifndef CRDIC_REGS_SVH
`define CRDIC_REGS_SVH
// Register byte offsets on the AXI4-Lite slave.
`define CRDIC_STATUS_OFS     8'h00
`define CRDIC_IMASK_OFS      8'h04
`define CRDIC_IPEND_OFS      8'h08
`define CRDIC_EXCADDR_OFS    8'h0C
`define CRDIC_RSTADDR_OFS    8'h10
`define CRDIC_BRKADDR_OFS    8'h14
`define CRDIC_CTLSTAT_OFS    8'h18
// Status register fields.
`define CRDIC_GIE_BIT        0
`define CRDIC_SAVED_GIE_BIT  1
`define CRDIC_LEVEL_LSB      8
// Control/state register fields.
`define CRDIC_STATE_LSB      0
`define CRDIC_CAUSE_LSB      4
// Reset values.
`define CRDIC_EXCADDR_RST    32'h0000_0020
`define CRDIC_RSTADDR_RST    32'h0000_0000
`define CRDIC_BRKADDR_RST    32'h0000_0100
`define CRDIC_IMASK_RST      32'h0000_0000
// Cycles between reset-address reads and acknowledge pulses while held.
`define CRDIC_FETCH_PERIOD   16
`endif

/* hw/crdic_pkg.sv */
package crdic_pkg;
  // Controller states, one-hot.
  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_DRAIN = 4'h2,
    ST_RESET = 4'h4,
    ST_PAUSE = 4'h8
  } crdic_state_t;
  // Reason the pipeline is being drained.
  typedef enum logic [2:0] {
    WHY_NONE  = 3'h0,
    WHY_RESET = 3'h1,
    WHY_DEBUG = 3'h2,
    WHY_EXC   = 3'h3,
    WHY_IINT  = 3'h4,
    WHY_EINT  = 3'h5,
    WHY_NMI   = 3'h6
  } crdic_why_t;
endpackage

/* hw/crdic_ctrl.sv */
`timescale 1ns/100ps
`include "crdic_regs.svh"
// Function
// - Global reset puts the core into reset at once, no draining.
// - Local reset request drains the pipeline first, then enters reset.
// - Acknowledge is a one-cycle pulse, repeated periodically while request stays.
// - Core stays in reset as long as local reset request is high.
// - While held in reset, reset address reads recur and data is discarded.
// - Local reset request is ignored while paused under debug control.
// - Still-asserted reset request is honoured on every debug release.
// - Debug request pauses like a breakpoint, jumps to break address, acknowledges.
// - Debug request while already paused has no effect.
// - All exceptions and internal interrupts go to one exception address.
// - Exceptions are precise: older done, younger not started.
// - External vector mode removes the internal interrupt controller.
// - Maskable external interrupts carry a level that gates acceptance.
// - Non-maskable external interrupts ignore level and global enable.
// - Thirty-two level-sensitive request lines, priority left to software.
// - Software mask register enables each request line individually.
// - Interrupt raised iff global enable, line asserted and mask bit set.
// - Nesting allowed once software re-enables interrupts in its handler.
module crdic_ctrl #(
  parameter int NIRQ         = 32,
  parameter int LVL_W        = 6,
  parameter int RS_W         = 6,
  parameter bit USE_EXT_VEC  = 1'b0,
  parameter int FETCH_PERIOD = `CRDIC_FETCH_PERIOD
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              reset_req,
  output logic                   reset_ack,
  output logic                   core_in_reset,
  output logic                   reset_fetch,
  output logic [31:0]            reset_fetch_addr,
  input  wire logic              debug_req,
  input  wire logic              debug_release,
  output logic                   debug_ack,
  input  wire logic              pipe_empty,
  input  wire logic              exc_req,
  output logic                   issue_stall,
  output logic                   redirect,
  output logic [31:0]            redirect_addr,
  output logic [RS_W-1:0]        regset_sel,
  input  wire logic [NIRQ-1:0]   irq,
  input  wire logic              ext_irq_valid,
  input  wire logic [31:0]       ext_handler_addr,
  input  wire logic [RS_W-1:0]   ext_regset,
  input  wire logic [LVL_W-1:0]  ext_level,
  input  wire logic              ext_nmi
);
  import crdic_pkg::*;

  localparam logic [7:0] PER_MAX = 8'(FETCH_PERIOD - 1);

  crdic_state_t     state_reg;
  crdic_state_t     state_next;
  crdic_why_t       why_reg;
  crdic_why_t       why_next;
  logic             gie_reg;
  logic             saved_gie_reg;
  logic [LVL_W-1:0] level_reg;
  logic [NIRQ-1:0]  mask_reg;
  logic [31:0]      exc_addr_reg;
  logic [31:0]      rst_addr_reg;
  logic [31:0]      brk_addr_reg;
  logic [7:0]       per_cnt_reg;
  logic             ack_reg;
  logic             redir_reg;
  logic [31:0]      redir_addr_reg;
  logic [RS_W-1:0]  regset_reg;
  logic             aw_held_reg;
  logic             w_held_reg;
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;
  logic             rvalid_reg;
  logic [1:0]       bresp_reg;
  logic             bvalid_reg;
  logic             int_raise;
  logic             ext_take;
  logic             wr_fire;
  logic             take_int;
  logic [NIRQ-1:0]  irq_pend;

  // Decodes a register offset; unmapped offsets return zero.
  function automatic logic addr_hit(input logic [7:0] a);
    return (a == `CRDIC_STATUS_OFS) || (a == `CRDIC_IMASK_OFS) || (a == `CRDIC_IPEND_OFS) ||
           (a == `CRDIC_EXCADDR_OFS) || (a == `CRDIC_RSTADDR_OFS) ||
           (a == `CRDIC_BRKADDR_OFS) || (a == `CRDIC_CTLSTAT_OFS);
  endfunction

  // Merges write data into a word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // The internal controller exists only without the external vector port.
  generate
    if (USE_EXT_VEC) begin : g_ext
      assign irq_pend  = '0;
      assign int_raise = 1'b0;
      assign ext_take  = ext_irq_valid && (ext_nmi || (gie_reg && (ext_level > level_reg)));
    end else begin : g_int
      assign irq_pend  = irq & mask_reg;
      assign int_raise = gie_reg && (|irq_pend);
      assign ext_take  = 1'b0;
    end
  endgenerate

  // Global reset forces reset at once; local reset follows the state.
  assign core_in_reset    = !aresetn || (state_reg == ST_RESET);
  assign issue_stall      = (state_reg != ST_RUN);
  assign debug_ack        = (state_reg == ST_PAUSE);
  assign reset_ack        = ack_reg;
  assign reset_fetch      = ack_reg;
  assign reset_fetch_addr = rst_addr_reg;
  assign redirect         = redir_reg;
  assign redirect_addr    = redir_addr_reg;
  assign regset_sel       = regset_reg;
  assign take_int         = (state_reg == ST_DRAIN) && pipe_empty &&
                            (why_reg == WHY_IINT || why_reg == WHY_EINT || why_reg == WHY_NMI || why_reg == WHY_EXC);

  // Next state: reset beats debug beats exceptions beats interrupts.
  always_comb begin
    state_next = state_reg;
    why_next   = why_reg;
    case (state_reg)
      ST_RUN: begin
        if (reset_req) begin
          state_next = ST_DRAIN;
          why_next   = WHY_RESET;
        end else if (debug_req) begin
          state_next = ST_DRAIN;
          why_next   = WHY_DEBUG;
        end else if (exc_req) begin
          state_next = ST_DRAIN;
          why_next   = WHY_EXC;
        end else if (ext_take) begin
          state_next = ST_DRAIN;
          why_next   = ext_nmi ? WHY_NMI : WHY_EINT;
        end else if (int_raise) begin
          state_next = ST_DRAIN;
          why_next   = WHY_IINT;
        end
      end
      ST_DRAIN: begin
        if (pipe_empty) begin
          why_next = WHY_NONE;
          case (why_reg)
            WHY_RESET: state_next = ST_RESET;
            WHY_DEBUG: state_next = ST_PAUSE;
            default:   state_next = ST_RUN;
          endcase
        end
      end
      ST_RESET: begin
        if (!reset_req) begin
          state_next = ST_RUN;
        end
      end
      ST_PAUSE: begin
        if (debug_release) begin
          state_next = reset_req ? ST_DRAIN : ST_RUN;
          why_next   = reset_req ? WHY_RESET : WHY_NONE;
        end
      end
      default: begin
        state_next = ST_RUN;
        why_next   = WHY_NONE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_RUN;
      why_reg   <= WHY_NONE;
    end else begin
      state_reg <= state_next;
      why_reg   <= why_next;
    end
  end

  // Acknowledge and reset-address read cadence while held in reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_reg <= 8'h00;
      ack_reg     <= 1'b0;
    end else if (state_reg != ST_RESET || !reset_req) begin
      per_cnt_reg <= 8'h00;
      ack_reg     <= (state_next == ST_RESET);
    end else begin
      ack_reg     <= (per_cnt_reg == PER_MAX);
      per_cnt_reg <= (per_cnt_reg == PER_MAX) ? 8'h00 : per_cnt_reg + 8'h01;
    end
  end

  // Redirect of the fetch stream: one address for every exception.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      redir_reg      <= 1'b0;
      redir_addr_reg <= 32'h0000_0000;
      regset_reg     <= '0;
    end else begin
      redir_reg <= 1'b0;
      if (state_reg == ST_DRAIN && pipe_empty && why_reg == WHY_DEBUG) begin
        redir_reg      <= 1'b1;
        redir_addr_reg <= brk_addr_reg;
      end else if (state_reg == ST_RESET && !reset_req) begin
        redir_reg      <= 1'b1;
        redir_addr_reg <= rst_addr_reg;
      end else if (take_int) begin
        redir_reg <= 1'b1;
        if (why_reg == WHY_EINT || why_reg == WHY_NMI) begin
          redir_addr_reg <= ext_handler_addr;
          regset_reg     <= ext_regset;
        end else begin
          redir_addr_reg <= exc_addr_reg;
        end
      end
    end
  end

  // Global enable, saved enable and current level; taking clears enable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_reg       <= 1'b0;
      saved_gie_reg <= 1'b0;
      level_reg     <= '0;
    end else if (state_reg == ST_RESET) begin
      gie_reg <= 1'b0;
    end else if (take_int) begin
      saved_gie_reg <= gie_reg;
      gie_reg       <= 1'b0;
      if (why_reg == WHY_EINT) begin
        level_reg <= ext_level;
      end
    end else if (wr_fire && aw_addr_reg == `CRDIC_STATUS_OFS && w_strb_reg[0]) begin
      gie_reg       <= w_data_reg[`CRDIC_GIE_BIT];
      saved_gie_reg <= w_data_reg[`CRDIC_SAVED_GIE_BIT];
      if (w_strb_reg[1]) begin
        level_reg <= w_data_reg[`CRDIC_LEVEL_LSB +: LVL_W];
      end
    end
  end

  // Software-written mask and address registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg     <= NIRQ'(`CRDIC_IMASK_RST);
      exc_addr_reg <= `CRDIC_EXCADDR_RST;
      rst_addr_reg <= `CRDIC_RSTADDR_RST;
      brk_addr_reg <= `CRDIC_BRKADDR_RST;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        `CRDIC_IMASK_OFS:   mask_reg     <= NIRQ'(merge(32'(mask_reg), w_data_reg, w_strb_reg));
        `CRDIC_EXCADDR_OFS: exc_addr_reg <= merge(exc_addr_reg, w_data_reg, w_strb_reg);
        `CRDIC_RSTADDR_OFS: rst_addr_reg <= merge(rst_addr_reg, w_data_reg, w_strb_reg);
        `CRDIC_BRKADDR_OFS: brk_addr_reg <= merge(brk_addr_reg, w_data_reg, w_strb_reg);
        default: ;
      endcase
    end
  end

  // AXI4-Lite write: address and data taken in either order, then response.
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= addr_hit(aw_addr_reg) ? 2'h0 : 2'h2;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // AXI4-Lite read: one cycle from address to data.
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= addr_hit({s_axi_araddr[7:2], 2'h0}) ? 2'h0 : 2'h2;
      rdata_reg  <= 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'h0})
        `CRDIC_STATUS_OFS: begin
          rdata_reg[`CRDIC_GIE_BIT]                <= gie_reg;
          rdata_reg[`CRDIC_SAVED_GIE_BIT]          <= saved_gie_reg;
          rdata_reg[`CRDIC_LEVEL_LSB +: LVL_W]     <= level_reg;
        end
        `CRDIC_IMASK_OFS:   rdata_reg <= 32'(mask_reg);
        `CRDIC_IPEND_OFS:   rdata_reg <= 32'(irq_pend);
        `CRDIC_EXCADDR_OFS: rdata_reg <= exc_addr_reg;
        `CRDIC_RSTADDR_OFS: rdata_reg <= rst_addr_reg;
        `CRDIC_BRKADDR_OFS: rdata_reg <= brk_addr_reg;
        `CRDIC_CTLSTAT_OFS: begin
          rdata_reg[`CRDIC_STATE_LSB +: 4] <= state_reg;
          rdata_reg[`CRDIC_CAUSE_LSB +: 3] <= why_reg;
        end
        default: ;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Checks on the controller's behaviour.
  sequence s_drained;
    (state_reg == ST_DRAIN) && pipe_empty;
  endsequence

  sequence s_held;
    (state_reg == ST_RESET) && reset_req;
  endsequence

  a_ack_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    reset_ack |=> !reset_ack) else $error("Reset acknowledge longer than one cycle.");

  a_reset_after_drain: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_drained ##0 (why_reg == WHY_RESET)) |=> (state_reg == ST_RESET) && reset_ack)
    else $error("Local reset not entered after draining.");

  a_reset_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_held |=> (state_reg == ST_RESET)) else $error("Reset left while request held.");

  a_reset_fetch_repeat: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_held ##0 (per_cnt_reg == PER_MAX)) |=> reset_fetch && reset_ack)
    else $error("Reset address read not repeated.");

  a_pause_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_PAUSE) && !debug_release |=> (state_reg == ST_PAUSE))
    else $error("Pause left without debug release.");

  a_release_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_PAUSE) && debug_release && reset_req |=> (state_reg == ST_DRAIN) && (why_reg == WHY_RESET))
    else $error("Reset request missed at debug release.");

  a_debug_break: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_drained ##0 (why_reg == WHY_DEBUG)) |=> debug_ack && redirect && (redirect_addr == brk_addr_reg))
    else $error("Debug pause did not go to break address.");

  a_single_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_drained ##0 (why_reg == WHY_EXC || why_reg == WHY_IINT)) |=> redirect && (redirect_addr == $past(exc_addr_reg)))
    else $error("Exception not sent to exception address.");

  a_precise_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_RUN) && exc_req && !reset_req && !debug_req |=> issue_stall [*1] ##0 (state_reg == ST_DRAIN))
    else $error("Exception did not stall issue.");

  a_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_RUN) && !reset_req && !debug_req && !exc_req && !USE_EXT_VEC && gie_reg && (|(irq & mask_reg))
    |=> (why_reg == WHY_IINT)) else $error("Enabled request not raised.");

  a_nmi_taken: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_RUN) && !reset_req && !debug_req && !exc_req && USE_EXT_VEC && ext_irq_valid && ext_nmi
    |=> (why_reg == WHY_NMI)) else $error("Non-maskable interrupt not taken.");

  a_nest_disable: assert property (@(posedge aclk) disable iff (!aresetn)
    take_int |=> !gie_reg && (saved_gie_reg == $past(gie_reg))) else $error("Enable not saved on entry.");
endmodule

/* tb/crdic_far_model.sv */
`timescale 1ns/100ps
module crdic_far_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       issue_stall,
  input  wire logic       redirect,
  input  wire logic       fault,
  input  wire logic [3:0] drain_cycles,
  output logic            pipe_empty,
  output logic            exc_req
);
  logic [3:0] cnt_reg;
  // Counts stalled cycles, so older instructions need drain_cycles cycles to retire.
  always_ff @(posedge aclk) begin
    if (!aresetn || !issue_stall) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != 4'hF) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // The pipeline reports empty only while issue is held off and the drain time is over.
  assign pipe_empty = issue_stall && (cnt_reg >= drain_cycles);
  // A faulting instruction is flushed by the redirect, so its request drops with it.
  assign exc_req = fault && !redirect;
endmodule

/* tb/test_cpu_reset_debug_interrupt_ctrl.sv */
`timescale 1ns/100ps
`include "crdic_regs.svh"
module test_cpu_reset_debug_interrupt_ctrl;
  localparam int FP = 4;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        reset_req, reset_ack, core_in_reset, reset_fetch, debug_req, debug_release, debug_ack;
  logic        pipe_empty, exc_req, issue_stall, redirect, fault;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, reset_fetch_addr, redirect_addr, irq;
  logic [3:0]  wstrb, drain;
  logic [1:0]  bresp, rresp;
  logic [5:0]  regset_sel;
  int          miscompares, checked, redirects;

  crdic_ctrl #(.FETCH_PERIOD(FP)) crdic_ctrl_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reset_req(reset_req), .reset_ack(reset_ack),
    .core_in_reset(core_in_reset), .reset_fetch(reset_fetch), .reset_fetch_addr(reset_fetch_addr),
    .debug_req(debug_req), .debug_release(debug_release), .debug_ack(debug_ack), .pipe_empty(pipe_empty),
    .exc_req(exc_req), .issue_stall(issue_stall), .redirect(redirect), .redirect_addr(redirect_addr),
    .regset_sel(regset_sel), .irq(irq), .ext_irq_valid(1'b0), .ext_handler_addr(32'h0000_0000),
    .ext_regset(6'h00), .ext_level(6'h00), .ext_nmi(1'b0));

  crdic_far_model crdic_far_model_i (
    .aclk(aclk), .aresetn(aresetn), .issue_stall(issue_stall), .redirect(redirect), .fault(fault),
    .drain_cycles(drain), .pipe_empty(pipe_empty), .exc_req(exc_req));

  // Clock of 5 ns period.
  always #2.5 aclk = ~aclk;

  // Counts redirect pulses so that a missing or extra take can be seen.
  always @(posedge aclk) begin
    if (redirect === 1'b1) redirects++;
  end

  // Prints the counts and the verdict, then ends the run.
  task final_report;
    $display("Counts: checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Compares one value against its expectation.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Picks the signal that a bounded wait watches.
  function automatic logic sel(input int s);
    case (s)
      0: sel = reset_ack;
      1: sel = redirect;
      2: sel = debug_ack;
      3: sel = bvalid;
      4: sel = arvalid & arready;
      default: sel = rvalid;
    endcase
  endfunction

  // Waits at falling edges until the chosen signal is high; gives up after 80 cycles.
  task automatic wt(input int s, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (sel(s) !== 1'b1 && n < 80);
    if (sel(s) !== 1'b1) begin
      miscompares++;
      final_report;
    end
  endtask

  // One register write; address and data are released each on its own acceptance.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh;
    int n;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ah && wh)) begin
      @(negedge aclk);
      ah = ah | (awvalid & awready);
      wh = wh | (wvalid & wready);
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    wt(3, n);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  // One register read.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wt(4, n);
    @(posedge aclk);
    arvalid <= 1'b0;
    wt(5, n);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // Reset values, an unmapped offset and a reset address write.
  task t_regs;
    logic [7:0]  ofs [7];
    logic [31:0] rst [7];
    logic [31:0] d;
    logic [1:0]  r;
    ofs = '{`CRDIC_STATUS_OFS, `CRDIC_IMASK_OFS, `CRDIC_IPEND_OFS, `CRDIC_EXCADDR_OFS, `CRDIC_RSTADDR_OFS,
            `CRDIC_BRKADDR_OFS, `CRDIC_CTLSTAT_OFS};
    rst = '{32'h0, `CRDIC_IMASK_RST, 32'h0, `CRDIC_EXCADDR_RST, `CRDIC_RSTADDR_RST, `CRDIC_BRKADDR_RST, 32'h1};
    for (int i = 0; i < 7; i++) begin
      axi_rd(ofs[i], d, r);
      chk(d, rst[i]);
    end
    axi_rd(8'h1C, d, r);
    chk({30'h0, r}, 32'h2);
    axi_wr(8'h1C, 32'h5A5A_5A5A, r);
    chk({30'h0, r}, 32'h2);
    axi_wr(`CRDIC_RSTADDR_OFS, 32'h0000_0040, r);
    axi_rd(`CRDIC_RSTADDR_OFS, d, r);
    chk(d, 32'h0000_0040);
    $display("t_regs done");
  endtask

  // Local reset: drain first, periodic acknowledge and fetch, exit on release.
  task t_local_reset;
    int n;
    @(posedge aclk);
    drain <= 4'h3;
    reset_req <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    chk(issue_stall, 1);
    chk(core_in_reset, 0);
    wt(0, n);
    chk({reset_fetch, core_in_reset}, 2'b11);
    chk(reset_fetch_addr, 32'h0000_0040);
    wt(0, n);
    chk(n, FP);
    chk(core_in_reset, 1);
    @(posedge aclk);
    reset_req <= 1'b0;
    wt(1, n);
    chk(redirect_addr, 32'h0000_0040);
    chk(core_in_reset, 0);
    $display("t_local_reset done");
  endtask

  // Debug pause, ignored requests while paused, reset honoured on release.
  task t_debug;
    int n, c;
    @(posedge aclk);
    debug_req <= 1'b1;
    wt(2, n);
    chk(redirect, 1);
    chk(redirect_addr, `CRDIC_BRKADDR_RST);
    @(posedge aclk);
    reset_req <= 1'b1;
    @(negedge aclk);
    c = redirects;
    repeat (8) @(negedge aclk);
    chk(core_in_reset, 0);
    chk(debug_ack, 1);
    chk(redirects, c);
    @(posedge aclk);
    debug_req <= 1'b0;
    debug_release <= 1'b1;
    @(posedge aclk);
    debug_release <= 1'b0;
    wt(0, n);
    chk(core_in_reset, 1);
    @(posedge aclk);
    reset_req <= 1'b0;
    wt(1, n);
    $display("t_debug done");
  endtask

  // A fault waits for the slow drain, then goes to the exception address.
  task t_exc;
    int n;
    @(posedge aclk);
    drain <= 4'h6;
    fault <= 1'b1;
    wt(1, n);
    chk(n >= 8, 1);
    chk(redirect_addr, `CRDIC_EXCADDR_RST);
    @(posedge aclk);
    fault <= 1'b0;
    $display("t_exc done");
  endtask

  // Interrupt gating by global enable and mask, then a nested take.
  task t_irq;
    logic [31:0] d;
    logic [1:0]  r;
    int          n, c;
    axi_wr(`CRDIC_IMASK_OFS, 32'h8000_0000, r);
    irq <= 32'h8000_0020;
    c = redirects;
    repeat (6) @(negedge aclk);
    chk(redirects, c);
    axi_rd(`CRDIC_IPEND_OFS, d, r);
    chk(d, 32'h8000_0000);
    axi_wr(`CRDIC_STATUS_OFS, 32'h1, r);
    wt(1, n);
    chk(redirect_addr, `CRDIC_EXCADDR_RST);
    axi_rd(`CRDIC_STATUS_OFS, d, r);
    chk(d, 32'h0000_0002);
    axi_wr(`CRDIC_IMASK_OFS, 32'h1, r);
    c = redirects;
    axi_wr(`CRDIC_STATUS_OFS, 32'h1, r);
    repeat (10) @(negedge aclk);
    chk(redirects, c);
    axi_wr(`CRDIC_IMASK_OFS, 32'h20, r);
    wt(1, n);
    chk(redirect_addr, `CRDIC_EXCADDR_RST);
    irq <= 32'h0;
    $display("t_irq done");
  endtask

  // Global reset in mid-drain acts at once.
  task t_global_reset;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    fault <= 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b0;
    fault <= 1'b0;
    @(negedge aclk);
    chk(core_in_reset, 1);
    @(posedge aclk);
    @(negedge aclk);
    chk({core_in_reset, issue_stall, redirect}, 3'b100);
    @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`CRDIC_CTLSTAT_OFS, d, r);
    chk(d, 32'h1);
    $display("t_global_reset done");
  endtask

  // Main sequence.
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, reset_req, debug_req, debug_release, fault} = 9'h000;
    {awaddr, araddr, wdata, irq} = 80'h0;
    wstrb = 4'hF;
    drain = 4'h2;
    {miscompares, checked, redirects} = {32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_local_reset;
    t_debug;
    t_exc;
    t_irq;
    t_global_reset;
    final_report;
  end
endmodule
